// [src/tmr_core.sv]
// 16-bit timer core with byte-wide apb register access
// assumes outside prescaler taps on pclk
// assumes outside waveform logic
//
// Our own choices: the APB slave port and the register offsets.
`include "tmr_cfg.svh"
module tmr_core import tmr_pkg::*; (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [3:0]   presc_tick,
    input  wire logic         external_count_pin,
    input  wire logic         capture_input_pin,
    input  wire logic         capture_input_a,
    input  wire logic         capture_input_b,
    input  wire logic         clear_req,
    output logic              timer_tick,
    output logic      [15:0]  count_value,
    output logic      [15:0]  top_value,
    output logic              at_bottom,
    output logic              at_max,
    output logic              at_top,
    output logic              cmpa_match,
    output logic              cmpb_match,
    output logic              capture_event,
    output logic              cmpa_pwm_ok,
    output logic      [3:0]   irq_req
);

    // ****************************************************
    // state
    // ****************************************************
    logic [7:0]  ctrl_q;
    logic [2:0]  clksel_q;
    logic        pwr_off_q;
    logic [7:0]  hold_q;
    logic [7:0]  hold_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] cmpa_buf_q;
    logic [15:0] cmpa_q;
    logic [15:0] cmpb_buf_q;
    logic [15:0] cmpb_q;
    logic [15:0] cap_q;
    logic [15:0] cap_d;
    logic [3:0]  flag_q;
    logic [3:0]  flag_d;
    logic [3:0]  mask_q;
    logic        block_q;
    logic        rtg_q;
    logic [31:0] prdata_q;
    logic        perr_q;

    // ****************************************************
    // apb decode
    // ****************************************************
    wire [5:0] off      = paddr[5:0];
    wire       in_range = (paddr[11:6] == 6'h00) && (off[1:0] == 2'b00);
    wire       s_ctrl   = off == `TMR_OFF_CTRL;
    wire       s_clk    = off == `TMR_OFF_CLKSEL;
    wire       s_cnt_l  = off == `TMR_OFF_CNT_L;
    wire       s_cnt_h  = off == `TMR_OFF_CNT_H;
    wire       s_cma_l  = off == `TMR_OFF_CMPA_L;
    wire       s_cma_h  = off == `TMR_OFF_CMPA_H;
    wire       s_cmb_l  = off == `TMR_OFF_CMPB_L;
    wire       s_cmb_h  = off == `TMR_OFF_CMPB_H;
    wire       s_cap_l  = off == `TMR_OFF_CAP_L;
    wire       s_cap_h  = off == `TMR_OFF_CAP_H;
    wire       s_flag   = off == `TMR_OFF_FLAG;
    wire       s_mask   = off == `TMR_OFF_MASK;
    wire       s_pwr    = off == `TMR_OFF_POWER;
    wire       hit      = in_range & (s_ctrl | s_clk | s_cnt_l |
                          s_cnt_h | s_cma_l | s_cma_h | s_cmb_l |
                          s_cmb_h | s_cap_l | s_cap_h | s_flag |
                          s_mask | s_pwr);
    wire       any_high = s_cnt_h | s_cma_h | s_cmb_h | s_cap_h;

    // reads sample at setup; writes act in access
    wire setup  = psel & ~penable;
    wire rd_stp = setup & ~pwrite & hit;
    wire wr_acc = psel & penable & pwrite & ~perr_q;
    wire [7:0] wb = pwdata[7:0];

    wire w_ctrl  = wr_acc & s_ctrl;
    wire w_clk   = wr_acc & s_clk;
    wire w_cnt   = wr_acc & s_cnt_l;
    wire w_cma   = wr_acc & s_cma_l;
    wire w_cmb   = wr_acc & s_cmb_l;
    wire w_cap   = wr_acc & s_cap_l;
    wire w_flag  = wr_acc & s_flag;
    wire w_mask  = wr_acc & s_mask;
    wire w_pwr   = wr_acc & s_pwr;
    wire w_high  = wr_acc & any_high;

    // ****************************************************
    // mode decode
    // ****************************************************
    tmr_top_t top_sel;
    assign top_sel = tmr_top_t'(ctrl_q[2:0]);
    wire dir_down = ctrl_q[`TMR_CTRL_DIR];
    wire filt_en  = ctrl_q[`TMR_CTRL_FILT];
    wire cap_fall = ctrl_q[`TMR_CTRL_CEDGE];
    wire pwm_mode = ctrl_q[`TMR_CTRL_PWM];
    wire rtg_en   = ctrl_q[`TMR_CTRL_RTG];

    // fixed, compare a or capture top; else max
    assign top_value = (top_sel == TOP_FIX8)  ? `TMR_TOP_FIX8  :
                       (top_sel == TOP_FIX9)  ? `TMR_TOP_FIX9  :
                       (top_sel == TOP_FIX10) ? `TMR_TOP_FIX10 :
                       (top_sel == TOP_CMPA)  ? cmpa_q :
                       (top_sel == TOP_CAP)   ? cap_q  :
                       `TMR_CNT_MAX;

    assign at_bottom = cnt_q == `TMR_CNT_BOTTOM;
    assign at_max    = cnt_q == `TMR_CNT_MAX;
    assign at_top    = cnt_q == top_value;

    // compare a as top: no pwm output a
    assign cmpa_pwm_ok = ~(pwm_mode & (top_sel == TOP_CMPA));

    // ****************************************************
    // pins and tick
    // ****************************************************
    tmr_pin_if ext_ev ();
    tmr_pin_if cap_ev ();
    tmr_pin_if rta_ev ();
    tmr_pin_if rtb_ev ();

    tmr_pin_edge u_ext (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (external_count_pin),
        .filt_en (1'b0),
        .ev      (ext_ev)
    );
    tmr_pin_edge u_cap (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (capture_input_pin),
        .filt_en (filt_en),
        .ev      (cap_ev)
    );
    tmr_pin_edge u_rta (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (capture_input_a),
        .filt_en (filt_en),
        .ev      (rta_ev)
    );
    tmr_pin_edge u_rtb (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (capture_input_b),
        .filt_en (filt_en),
        .ev      (rtb_ev)
    );

    tmr_tick_sel u_tick (
        .clk_sel    (clksel_q),
        .presc_tick (presc_tick),
        .power_off  (pwr_off_q),
        .ext        (ext_ev),
        .timer_tick (timer_tick)
    );

    // ****************************************************
    // counter
    // ****************************************************
    wire tick     = timer_tick;
    wire wrap     = dir_down ? at_bottom : at_top;
    wire rtg_edge = cap_fall ? (rta_ev.fall | rtb_ev.fall)
                             : (rta_ev.rise | rtb_ev.rise);
    // retrigger waits for next tick
    wire rtg_fire = tick & (rtg_q | (rtg_en & rtg_edge));
    wire reload   = rtg_fire | (tick & wrap);
    wire [15:0] start_val = dir_down ? top_value : `TMR_CNT_BOTTOM;
    wire [15:0] step_val  = dir_down ? cnt_q - 16'h0001
                                     : cnt_q + 16'h0001;

    // cpu write beats clear; frozen without tick
    assign cnt_d = w_cnt     ? {hold_q, wb} :
                   clear_req ? `TMR_CNT_BOTTOM :
                   reload    ? start_val :
                   tick      ? step_val : cnt_q;
    assign count_value = cnt_q;

    wire ovf_ev = reload & ~w_cnt & ~clear_req;

    // ****************************************************
    // compare and capture
    // ****************************************************
    // a fresh cpu write to the count hides a match on the next tick
    assign cmpa_match = tick & ~block_q & (cnt_q == cmpa_q);
    assign cmpb_match = tick & ~block_q & (cnt_q == cmpb_q);

    // pwm: active copy moves only at cycle end
    wire cmp_load = ~pwm_mode | (tick & wrap);

    wire cap_edge = cap_fall ? cap_ev.fall : cap_ev.rise;
    assign capture_event = cap_edge & ~pwr_off_q &
                           (top_sel != TOP_CAP);
    assign cap_d = w_cap         ? {hold_q, wb} :
                   capture_event ? cnt_q : cap_q;

    // ****************************************************
    // flags: hardware set wins over software clear
    // ****************************************************
    wire [3:0] flag_set = {capture_event, cmpb_match,
                           cmpa_match, ovf_ev};
    wire [3:0] flag_clr = w_flag ? pwdata[3:0] : 4'h0;
    assign flag_d  = (flag_q & ~flag_clr) | flag_set;
    assign irq_req = flag_q & mask_q;

    // ****************************************************
    // shared high-byte holding register
    // ****************************************************
    // one holder for all: isr access corrupts a main-line pair
    assign hold_d = w_high             ? wb :
                    rd_stp & s_cnt_l   ? cnt_q[15:8] :
                    rd_stp & s_cap_l   ? cap_q[15:8] :
                    hold_q;

    // ****************************************************
    // read data
    // ****************************************************
    wire [7:0] rd_byte =
        s_ctrl  ? ctrl_q :
        s_clk   ? {5'h00, clksel_q} :
        s_cnt_l ? cnt_q[7:0] :
        s_cap_l ? cap_q[7:0] :
        (s_cnt_h | s_cap_h) ? hold_q :
        s_cma_l ? cmpa_buf_q[7:0] :
        s_cma_h ? cmpa_buf_q[15:8] :
        s_cmb_l ? cmpb_buf_q[7:0] :
        s_cmb_h ? cmpb_buf_q[15:8] :
        s_flag  ? {4'h0, flag_q} :
        s_mask  ? {4'h0, mask_q} :
        s_pwr   ? {7'h00, pwr_off_q} : 8'h00;

    assign pready  = psel & penable;
    assign pslverr = pready & perr_q;
    assign prdata  = prdata_q;

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            perr_q   <= 1'b0;
        end else if (setup) begin
            prdata_q <= rd_stp ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            perr_q   <= ~hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `TMR_CTRL_RST;
            clksel_q  <= `TMR_CLKSEL_RST;
            pwr_off_q <= `TMR_PWR_RST;
            mask_q    <= 4'h0;
        end else begin
            if (w_ctrl) ctrl_q <= wb;
            if (w_clk) clksel_q <= wb[2:0];
            if (w_pwr) pwr_off_q <= wb[0];
            if (w_mask) mask_q <= wb[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q  <= 8'h00;
            cnt_q   <= `TMR_CNT_BOTTOM;
            cap_q   <= `TMR_CNT_BOTTOM;
            flag_q  <= 4'h0;
        end else begin
            hold_q  <= hold_d;
            cnt_q   <= cnt_d;
            cap_q   <= cap_d;
            flag_q  <= flag_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpa_buf_q <= `TMR_CNT_BOTTOM;
            cmpb_buf_q <= `TMR_CNT_BOTTOM;
            cmpa_q     <= `TMR_CNT_BOTTOM;
            cmpb_q     <= `TMR_CNT_BOTTOM;
        end else begin
            if (w_cma) cmpa_buf_q <= {hold_q, wb};
            if (w_cmb) cmpb_buf_q <= {hold_q, wb};
            if (cmp_load) begin
                cmpa_q <= cmpa_buf_q;
                cmpb_q <= cmpb_buf_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
            rtg_q   <= 1'b0;
        end else begin
            block_q <= w_cnt | (block_q & ~tick);
            // new edge beats consumption
            rtg_q   <= (rtg_en & rtg_edge) | (rtg_q & ~tick);
        end
    end

endmodule : tmr_core

// [src/tmr_cfg.svh]
// timer core constants: offsets, fields, resets, limits
// assumes 32-bit apb, one byte register per word
// Contract
// - one 8-bit high-byte holding register
// - holder shared by all 16-bit registers
// - low-byte access does the 16-bit transfer
// - low write loads held high plus low
// - low read copies high byte to holder
// - compare reads bypass the holding register
// - counter frozen with no clock source
// - tick from direct, prescaler or pin edge
// - compares checked every timer tick except the first tick after a cpu count write
// - compare equality sets match flag
// - capture edge latches counter
// - optional capture noise filter
// - bottom flagged at zero
// - all-ones count is the maximum
// - top fixed, compare a, or capture
// - compare a as top drives no pwm
// - compare a top is double buffered (here only in pwm mode; otherwise the buffer is copied every cycle)
// - four flags, each with its own enable
// - disabled unless power-off bit cleared
// - count by one, direction select, clear
// - inputs a/b request top-like retrigger
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ****************************************************
// register byte offsets
// ****************************************************
`define TMR_OFF_CTRL    6'h00
`define TMR_OFF_CLKSEL  6'h04
`define TMR_OFF_CNT_L   6'h08
`define TMR_OFF_CNT_H   6'h0c
`define TMR_OFF_CMPA_L  6'h10
`define TMR_OFF_CMPA_H  6'h14
`define TMR_OFF_CMPB_L  6'h18
`define TMR_OFF_CMPB_H  6'h1c
`define TMR_OFF_CAP_L   6'h20
`define TMR_OFF_CAP_H   6'h24
`define TMR_OFF_FLAG    6'h28
`define TMR_OFF_MASK    6'h2c
`define TMR_OFF_POWER   6'h30

// ****************************************************
// field positions
// ****************************************************
`define TMR_CTRL_DIR    3
`define TMR_CTRL_FILT   4
`define TMR_CTRL_CEDGE  5
`define TMR_CTRL_PWM    6
`define TMR_CTRL_RTG    7
`define TMR_FLAG_OVF    0
`define TMR_FLAG_CMPA   1
`define TMR_FLAG_CMPB   2
`define TMR_FLAG_CAP    3

// ****************************************************
// reset values and count limits
// ****************************************************
`define TMR_CTRL_RST    8'h00
`define TMR_CLKSEL_RST  3'h0
`define TMR_PWR_RST     1'b1
`define TMR_CNT_BOTTOM  16'h0000
`define TMR_CNT_MAX     16'hffff
`define TMR_TOP_FIX8    16'h00ff
`define TMR_TOP_FIX9    16'h01ff
`define TMR_TOP_FIX10   16'h03ff
`define TMR_FILT_LEN    4

`endif

// [src/tmr_pkg.sv]
// types shared by the timer core modules
// numbers live in tmr_cfg.svh
package tmr_pkg;
    typedef enum logic [2:0] {
        CLK_OFF, CLK_DIV1, CLK_DIV8, CLK_DIV64,
        CLK_DIV256, CLK_DIV1024, CLK_EXT_FALL, CLK_EXT_RISE
    } tmr_clk_t;
    typedef enum logic [2:0] {
        TOP_MAX, TOP_FIX8, TOP_FIX9, TOP_FIX10, TOP_CMPA, TOP_CAP
    } tmr_top_t;
endpackage : tmr_pkg

// [src/tmr_pin_if.sv]
// edge events of one synchronised timer pin
// assumes driver and user share pclk
interface tmr_pin_if;
    logic rise;
    logic fall;
    modport drv (output rise, output fall);
    modport usr (input rise, input fall);
endinterface : tmr_pin_if

// [src/tmr_pin_edge.sv]
// pin sync, optional filter, edge detect
// assumes pin is asynchronous to pclk
module tmr_pin_edge import tmr_pkg::*; #(
    parameter int FILT_LEN = `TMR_FILT_LEN
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  pin,
    input  wire logic  filt_en,
    tmr_pin_if.drv     ev
);
    logic [1:0]          sync_q;
    logic [FILT_LEN-1:0] hist_q;
    logic                lvl_q;
    logic                lvl_d;
    wire                 all_hi = &hist_q;
    wire                 all_lo = ~|hist_q;

    // filter on: level moves only after a run of equal samples; filter off: follows the synchroniser
    assign lvl_d = !filt_en ? sync_q[1] :
                   all_hi   ? 1'b1 :
                   all_lo   ? 1'b0 : lvl_q;
    assign ev.rise = lvl_d & ~lvl_q;
    assign ev.fall = ~lvl_d & lvl_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 2'b00;
            hist_q <= '0;
            lvl_q  <= 1'b0;
        end else begin
            sync_q <= {sync_q[0], pin};
            hist_q <= {hist_q[FILT_LEN-2:0], sync_q[1]};
            lvl_q  <= lvl_d;
        end
    end
endmodule : tmr_pin_edge

// [src/tmr_tick_sel.sv]
// clock select: timer tick from chosen source
// assumes prescaler taps are one-cycle enables on pclk
module tmr_tick_sel import tmr_pkg::*; (
    input  wire logic  [2:0] clk_sel,
    input  wire logic  [3:0] presc_tick,
    input  wire logic        power_off,
    tmr_pin_if.usr           ext,
    output logic             timer_tick
);
    tmr_clk_t sel;
    logic     raw_tick;

    assign sel = tmr_clk_t'(clk_sel);
    // no source selected: no tick at all
    assign raw_tick = (sel == CLK_DIV1)     ? 1'b1 :
                      (sel == CLK_DIV8)     ? presc_tick[0] :
                      (sel == CLK_DIV64)    ? presc_tick[1] :
                      (sel == CLK_DIV256)   ? presc_tick[2] :
                      (sel == CLK_DIV1024)  ? presc_tick[3] :
                      (sel == CLK_EXT_FALL) ? ext.fall :
                      (sel == CLK_EXT_RISE) ? ext.rise : 1'b0;
    assign timer_tick = raw_tick & ~power_off;
endmodule : tmr_tick_sel

// [sim/tmr_core_properties.sv]
// port checker for the timer core
// assumes bind onto tmr_core; retrigger off
`include "tmr_cfg.svh"
module tmr_core_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        clear_req,
    input wire logic        timer_tick,
    input wire logic [15:0] count_value,
    input wire logic [15:0] top_value,
    input wire logic        at_bottom,
    input wire logic        at_max,
    input wire logic        at_top,
    input wire logic        cmpa_match,
    input wire logic        cmpb_match,
    input wire logic        capture_event
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************
    // properties
    // ****************************************************
    wire cnt_wr = psel && penable && pwrite &&
                  paddr == {6'h00, `TMR_OFF_CNT_L};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_bottom_flag: assert property (
        at_bottom == (count_value == 16'h0000)) else $error("bottom bad");
    a_max_flag: assert property (
        at_max == (count_value == 16'hffff)) else $error("max bad");
    a_top_flag: assert property (
        at_top == (count_value == top_value)) else $error("top bad");
    a_count_frozen: assert property (
        !timer_tick && !clear_req && !cnt_wr |=> $stable(count_value))
        else $error("count moved without tick");
    a_count_step: assert property (
        timer_tick && !clear_req && !cnt_wr && !at_top && !at_bottom
        |=> count_value == $past(count_value) + 16'h0001 ||
            count_value == $past(count_value) - 16'h0001)
        else $error("count step not one");
    a_clear_zero: assert property (
        clear_req && !cnt_wr |=> count_value == 16'h0000)
        else $error("clear ignored");
    a_low_write: assert property (
        cnt_wr |=> count_value[7:0] == $past(pwdata[7:0]))
        else $error("low byte write lost");
    a_cmpa_tick: assert property (
        cmpa_match |-> timer_tick) else $error("match a off tick");
    a_cmpb_tick: assert property (
        cmpb_match |-> timer_tick) else $error("match b off tick");
    a_err_access: assert property (
        pslverr |-> pready && psel && penable) else $error("stray error");
    c_match_b: cover property (cmpb_match);
    c_capture: cover property (capture_event);
    c_cnt_wr: cover property (cnt_wr);
endmodule : tmr_core_chk

bind tmr_core tmr_core_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .clear_req(clear_req), .timer_tick(timer_tick),
    .count_value(count_value), .top_value(top_value),
    .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top),
    .cmpa_match(cmpa_match), .cmpb_match(cmpb_match),
    .capture_event(capture_event));

// [sim/tmr_cpu_model.sv]
// apb master standing in for the cpu side of the timer
// assumes any wait states; ends at pready high
module tmr_cpu_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        last_err = 1'b0;
    end
    task xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
              output logic [7:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {6'h00, a};
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released data inverted
        pwdata  <= ~pwdata;
    endtask : xfer
    task wr16(input logic [5:0] lo, input logic [15:0] v);
        logic [7:0] q;
        xfer(1'b1, lo + 6'h04, v[15:8], q);
        xfer(1'b1, lo, v[7:0], q);
    endtask : wr16
    task rd16(input logic [5:0] lo, output logic [15:0] v);
        xfer(1'b0, lo, 8'h00, v[7:0]);
        xfer(1'b0, lo + 6'h04, 8'h00, v[15:8]);
    endtask : rd16
endmodule : tmr_cpu_model

// [sim/testbench.sv]
// self-checking bench for tmr_core
// assumes tmr_cpu_model and the bound checker
`include "tmr_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, clr, ext_pin, cap_pin;
    logic [3:0]  presc;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] count_value, top_value, v, r;
    logic [3:0]  irq_req;
    logic [7:0]  q;
    logic        at_bottom;
    int          miscompares, samples_checked, cycles, mcnt, mtop, i;
    int          seed;
    bit          mdn, movf;
    logic [15:0] tops [4] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff};

    tmr_cpu_model i_cpu (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    tmr_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .presc_tick(presc),
        .external_count_pin(ext_pin), .capture_input_pin(cap_pin),
        .capture_input_a(1'b0), .capture_input_b(1'b0),
        .clear_req(clr), .timer_tick(), .count_value(count_value),
        .top_value(top_value), .at_bottom(at_bottom), .at_max(),
        .at_top(), .cmpa_match(), .cmpb_match(), .capture_event(),
        .cmpa_pwm_ok(), .irq_req(irq_req));

    // ****************************************************
    // clock, timeout, checks
    // ****************************************************
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            end_sim();
        end
    end
    task chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk_word
    task chk_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %b got %b", n, e, g);
        end
    endtask : chk_bit
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    // one tick from source sel 2 to 7; sel 0 and 1 only pulse all prescaler taps
    task tick(input int sel);
        if (sel >= 6) begin
            ext_pin <= (sel == 6);
            repeat (6) @(posedge pclk);
            ext_pin <= (sel == 7);
        end else begin
            presc <= (sel < 2) ? 4'hf : 4'h1 << (sel - 2);
            @(posedge pclk);
            presc <= 4'h0;
        end
        repeat (6) @(posedge pclk);
    endtask : tick
    task step;
        movf = movf | (mdn ? mcnt == 0 : mcnt == mtop);
        if (!mdn) begin
            mcnt = (mcnt == mtop) ? 0 : mcnt + 1;
        end else begin
            mcnt = (mcnt == 0) ? mtop : mcnt - 1;
        end
    endtask : step
    task wr(input logic [5:0] a, input logic [7:0] d);
        i_cpu.xfer(1'b1, a, d, q);
        @(negedge pclk);
    endtask : wr

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        seed = 32'h6cd3_a4cc;
        pclk = 1'b0;
        presetn = 1'b0;
        clr = 1'b0;
        ext_pin = 1'b0;
        cap_pin = 1'b0;
        presc = 4'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk_bit("bottom", 1'b1, at_bottom);
        chk_word("top", 16'hffff, top_value);
        i_cpu.xfer(1'b0, `TMR_OFF_POWER, 8'h00, q);
        chk_word("power", 16'h0001, {8'h00, q});
        $display("test reset done");
        v = $random(seed);
        i_cpu.wr16(`TMR_OFF_CNT_L, v);
        wr(`TMR_OFF_CLKSEL, 8'h02);
        tick(2);
        chk_word("count off", v, count_value);
        wr(`TMR_OFF_POWER, 8'h00);
        wr(`TMR_OFF_CLKSEL, 8'h00);
        tick(0);
        i_cpu.rd16(`TMR_OFF_CNT_L, r);
        chk_word("count rd", v, r);
        wr(`TMR_OFF_CNT_H, 8'h5a);
        chk_word("count hold", v, count_value);
        wr(`TMR_OFF_CMPA_L, 8'h34);
        i_cpu.rd16(`TMR_OFF_CMPA_L, r);
        chk_word("cmpa rd", 16'h5a34, r);
        i_cpu.xfer(1'b0, `TMR_OFF_CNT_H, 8'h00, q);
        chk_word("holder", 16'h005a, {8'h00, q});
        wr(`TMR_OFF_CTRL, 8'h04);
        chk_word("top cmpa", 16'h5a34, top_value);
        for (i = 0; i < 4; i++) begin
            wr(`TMR_OFF_CTRL, i[7:0]);
            chk_word("top fixed", tops[i], top_value);
        end
        wr(`TMR_OFF_CTRL, 8'h00);
        $display("test access done");
        mcnt = v;
        mtop = 16'hffff;
        mdn = 1'b0;
        for (i = 2; i < 8; i++) begin
            wr(`TMR_OFF_CLKSEL, i[7:0]);
            tick(i);
            step();
            chk_word("count src", mcnt[15:0], count_value);
        end
        $display("test sources done");
        wr(`TMR_OFF_CLKSEL, 8'h02);
        wr(`TMR_OFF_FLAG, 8'h0f);
        wr(`TMR_OFF_MASK, 8'h01);
        for (i = 0; i < 2; i++) begin
            mdn = i[0];
            wr(`TMR_OFF_CTRL, mdn ? 8'h09 : 8'h01);
            mcnt = mdn ? 1 : 16'h00fd;
            mtop = 16'h00ff;
            movf = 1'b0;
            i_cpu.wr16(`TMR_OFF_CNT_L, mcnt[15:0]);
            repeat (4) begin
                tick(2);
                step();
                chk_word("count wrap", mcnt[15:0], count_value);
                chk_bit("ovf irq", movf, irq_req[0]);
            end
            wr(`TMR_OFF_FLAG, 8'h01);
            chk_bit("ovf clr", 1'b0, irq_req[0]);
        end
        $display("test wrap done");
        wr(`TMR_OFF_CTRL, 8'h00);
        wr(`TMR_OFF_MASK, 8'h04);
        i_cpu.wr16(`TMR_OFF_CMPB_L, 16'h0002);
        i_cpu.wr16(`TMR_OFF_CNT_L, 16'h0000);
        wr(`TMR_OFF_FLAG, 8'h0f);
        mcnt = 0;
        mdn = 1'b0;
        mtop = 16'hffff;
        repeat (3) begin
            tick(2);
            step();
            chk_bit("cmpb irq", mcnt == 3, irq_req[2]);
        end
        wr(`TMR_OFF_MASK, 8'h08);
        chk_bit("cmpb mask", 1'b0, irq_req[2]);
        $display("test compare done");
        wr(`TMR_OFF_CLKSEL, 8'h00);
        wr(`TMR_OFF_CTRL, 8'h10);
        cap_pin <= 1'b1;
        repeat (2) @(posedge pclk);
        cap_pin <= 1'b0;
        repeat (12) @(posedge pclk);
        chk_bit("spike", 1'b0, irq_req[3]);
        cap_pin <= 1'b1;
        repeat (16) @(posedge pclk);
        chk_bit("cap irq", 1'b1, irq_req[3]);
        i_cpu.rd16(`TMR_OFF_CAP_L, r);
        chk_word("cap rd", mcnt[15:0], r);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        @(posedge pclk);
        chk_word("clear", 16'h0000, count_value);
        i_cpu.xfer(1'b0, 6'h34, 8'h00, q);
        chk_bit("unmapped", 1'b1, i_cpu.last_err);
        $display("test capture done");
        end_sim();
    end
endmodule : testbench
